//--- pkg/adc_seq_pkg.sv
// Purpose: shared constants and types for the converter sequencer
// Assumes: 32-bit apb, one word per register
// Notes: offsets are byte addresses
package adc_seq_pkg;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] OFS_CONTROL_ZERO = 8'h00;
  localparam logic [7:0] OFS_CONTROL_TWO = 8'h04;
  localparam logic [7:0] OFS_FLAGS = 8'h08;
  localparam logic [7:0] OFS_RESULT_HIGH = 8'h0c;
  localparam logic [7:0] OFS_RESULT_LOW = 8'h10;

  // ****************************************
  // field positions
  // ****************************************
  localparam int BIT_ENABLE = 0;
  localparam int BIT_START = 1;
  localparam int POS_CHANNEL = 2;
  localparam int BIT_JUSTIFY = 7;
  localparam int POS_ACQ = 3;
  localparam int POS_CLKSEL = 0;
  localparam int BIT_DONE = 0;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [2:0] RST_ACQ = 3'h0;
  localparam logic [2:0] RST_CLKSEL = 3'h0;
  localparam logic [3:0] RST_CHANNEL = 4'h0;

  // ****************************************
  // timing counts in bit periods and clocks
  // ****************************************
  localparam logic [4:0] CONV_TADS = 5'h0b;
  localparam logic [4:0] WAIT_TADS = 5'h02;
  localparam logic [2:0] INSTR_CLKS = 3'h4;

  typedef enum logic [2:0] {ST_SAMPLE, ST_DELAY, ST_ACQ, ST_CONV, ST_WAIT} conv_state_e;

  // acquisition length in bit periods
  function automatic logic [4:0] acqTads(input logic [2:0] sel);
    case (sel)
      3'h1: acqTads = 5'h02;
      3'h2: acqTads = 5'h04;
      3'h3: acqTads = 5'h06;
      3'h4: acqTads = 5'h08;
      3'h5: acqTads = 5'h0c;
      3'h6: acqTads = 5'h10;
      3'h7: acqTads = 5'h14;
      default: acqTads = 5'h00;
    endcase
  endfunction : acqTads

  // oscillator periods per bit period
  function automatic logic [6:0] tadDivisor(input logic [2:0] sel);
    case (sel)
      3'h0: tadDivisor = 7'h02;
      3'h4: tadDivisor = 7'h04;
      3'h1: tadDivisor = 7'h08;
      3'h5: tadDivisor = 7'h10;
      3'h2: tadDivisor = 7'h20;
      3'h6: tadDivisor = 7'h40;
      default: tadDivisor = 7'h02;
    endcase
  endfunction : tadDivisor

  function automatic logic isRcSel(input logic [2:0] sel);
    isRcSel = (sel[1:0] == 2'h3);
  endfunction : isRcSel

endpackage : adc_seq_pkg

//--- verification/adc_acquisition_clock_control_tb_top.sv
// Purpose: self-checking bench for the converter sequencer
// Assumes: zero-wait apb slave, 125 MHz clk
// Notes: reset and refusal first, then row table, rc, abort and reset cases
`timescale 1ns/1ps
`default_nettype none
module adc_acquisition_clock_control_tb_top;
  typedef struct {logic [2:0] cs; logic [2:0] acq; int div; logic just; logic [9:0] lvl;} row_s;
  row_s rows [8] = '{
    '{3'h0, 3'h0, 2, 1'b1, 10'h3ff},
    '{3'h4, 3'h1, 4, 1'b0, 10'h000},
    '{3'h1, 3'h2, 8, 1'b1, 10'h2aa},
    '{3'h5, 3'h3, 16, 1'b0, 10'h155},
    '{3'h2, 3'h4, 32, 1'b1, 10'h201},
    '{3'h6, 3'h5, 64, 1'b0, 10'h1fe},
    '{3'h0, 3'h6, 2, 1'b1, 10'h000},
    '{3'h4, 3'h7, 4, 1'b0, 10'h33c}};
  int acqLen [8] = '{0, 2, 4, 6, 8, 12, 16, 20};
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, serr, lost;
  logic cmpHigh, rcClk, rcOn, sampling, converting, moduleOn;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [9:0] sarCode, level;
  logic [3:0] channel;
  logic [15:0] res;
  int num_errors, tests_run, cyc, n;
  row_s r;

  adc_acq_clock_ctrl dut
  (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rcClk(rcClk), .cmpHigh(cmpHigh), .sarCode(sarCode), .sampling(sampling),
    .converting(converting), .channel(channel), .moduleOn(moduleOn)
  );
  sar_analog_model analog
  (
    .level(level), .sarCode(sarCode), .rcOn(rcOn), .cmpHigh(cmpHigh), .rcClk(rcClk)
  );

  // ****************************************
  // clock, timeout, helpers
  // ****************************************
  initial
  begin
    clk = 1'b0;
    forever
    begin
      #4 clk = ~clk;
    end
  end

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      num_errors++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
    begin
      $display("ALL TESTS PASSED");
    end
    else
    begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: %s got %h want %h", $time, msg, got, exp);
    end
  endtask : check

  task automatic inRange(input int v, input int lo, input int hi, input string msg);
    tests_run++;
    if (v < lo || v > hi)
    begin
      num_errors++;
      $display("mismatch at %0t: %s %0d not in %0d..%0d", $time, msg, v, lo, hi);
    end
  endtask : inRange

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    rdata = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string msg);
    apb(1'b0, a, 32'h0);
    check(rdata, exp, msg);
  endtask : rd

  // s 0 watches converting, 1 sampling; counts edges until level v
  task automatic waitSig(input int s, input logic v, output int k);
    k = 0;
    while ((s == 0 ? converting : sampling) !== v && k < 3000)
    begin
      if (s == 0 && v && k > 0 && sampling !== 1'b1)
      begin
        lost = 1'b1;
      end
      @(posedge clk);
      k++;
    end
  endtask : waitSig

  task automatic conv(input int dlo, input int dhi, input int c, input int w, input int t);
    int k;
    lost = 1'b0;
    waitSig(0, 1'b1, k);
    inRange(k, dlo, dhi, "start delay");
    check(lost, 1'b0, "sampling during acquisition");
    waitSig(0, 1'b0, k);
    inRange(k, c - t, c + t, "conversion length");
    waitSig(1, 1'b1, k);
    inRange(k, w - t, w + t + 1, "resample wait");
  endtask : conv

  function automatic logic [15:0] fmt(input logic j, input logic [9:0] v);
    fmt = j ? {6'h0, v[9:8], v[7:0]} : {v[9:2], v[1:0], 6'h0};
  endfunction : fmt

  task automatic results(input logic [15:0] e);
    rd(adc_seq_pkg::OFS_RESULT_HIGH, {24'h0, e[15:8]}, "result high");
    rd(adc_seq_pkg::OFS_RESULT_LOW, {24'h0, e[7:0]}, "result low");
  endtask : results

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    level = 10'h000;
    rcOn = 1'b0;
    num_errors = 0;
    tests_run = 0;
    cyc = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(adc_seq_pkg::OFS_CONTROL_TWO, 32'h0, "control two reset");
    rd(adc_seq_pkg::OFS_FLAGS, 32'h0, "flags reset");
    rd(8'h14, 32'h0, "unmapped read");
    check(serr, 1'b1, "unmapped error");
    apb(1'b1, adc_seq_pkg::OFS_CONTROL_ZERO, 32'h2);
    rd(adc_seq_pkg::OFS_CONTROL_ZERO, 32'h0, "start while off");
    $display("reset and refusal done");
    for (int i = 0; i < 8; i++)
    begin
      r = rows[i];
      level <= r.lvl;
      apb(1'b1, adc_seq_pkg::OFS_CONTROL_TWO, {24'h0, r.just, 1'b0, r.acq, r.cs});
      apb(1'b1, adc_seq_pkg::OFS_CONTROL_ZERO, {26'h0, i[3:0], 2'h1});
      apb(1'b1, adc_seq_pkg::OFS_CONTROL_ZERO, {26'h0, i[3:0], 2'h3});
      conv(acqLen[r.acq] * r.div, acqLen[r.acq] * r.div + 3, 11 * r.div, 2 * r.div, 1);
      results(fmt(r.just, r.lvl));
      rd(adc_seq_pkg::OFS_CONTROL_ZERO, {26'h0, i[3:0], 2'h1}, "start cleared");
      rd(adc_seq_pkg::OFS_FLAGS, 32'h1, "done set");
      apb(1'b1, adc_seq_pkg::OFS_FLAGS, 32'h1);
      rd(adc_seq_pkg::OFS_FLAGS, 32'h0, "done cleared");
      check({26'h0, moduleOn, channel, sampling}, {26'h0, 1'b1, i[3:0], 1'b1}, "outputs");
      $display("row %0d done", i);
    end
    rcOn <= 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      level <= 10'h2c5 + i[9:0];
      apb(1'b1, adc_seq_pkg::OFS_CONTROL_TWO, {24'h0, 5'h10, i[0], 2'h3});
      apb(1'b1, adc_seq_pkg::OFS_CONTROL_ZERO, 32'h3);
      conv(4, 8, 70, 10, 6);
      res = fmt(1'b1, 10'h2c5 + i[9:0]);
      results(res);
      apb(1'b1, adc_seq_pkg::OFS_FLAGS, 32'h1);
      rd(adc_seq_pkg::OFS_FLAGS, 32'h0, "rc done cleared");
      $display("rc case %0d done", i);
    end
    rcOn <= 1'b0;
    level <= 10'h0aa;
    apb(1'b1, adc_seq_pkg::OFS_CONTROL_TWO, 32'h3e);
    apb(1'b1, adc_seq_pkg::OFS_CONTROL_ZERO, 32'h3);
    repeat (20) @(posedge clk);
    rd(adc_seq_pkg::OFS_CONTROL_ZERO, 32'h3, "start during acquisition");
    rd(adc_seq_pkg::OFS_FLAGS, 32'h0, "no acquisition status");
    check(converting, 1'b0, "not yet converting");
    waitSig(0, 1'b1, n);
    repeat (100) @(posedge clk);
    apb(1'b1, adc_seq_pkg::OFS_CONTROL_ZERO, 32'h1);
    waitSig(0, 1'b0, n);
    inRange(n, 0, 2, "abort stops conversion");
    waitSig(1, 1'b1, n);
    inRange(n, 125, 131, "wait after abort");
    results(res);
    rd(adc_seq_pkg::OFS_FLAGS, 32'h0, "no done on abort");
    $display("abort case done");
    apb(1'b1, adc_seq_pkg::OFS_CONTROL_TWO, 32'h06);
    apb(1'b1, adc_seq_pkg::OFS_CONTROL_ZERO, 32'h3);
    repeat (30) @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    check({converting, sampling}, 2'b00, "reset stops conversion");
    rst_n <= 1'b1;
    @(posedge clk);
    rd(adc_seq_pkg::OFS_CONTROL_TWO, 32'h0, "select cleared");
    $display("reset case done");
    close_out();
  end
endmodule : adc_acquisition_clock_control_tb_top
`default_nettype wire

//--- verification/sar_analog_model.sv
// Purpose: analog input and rc oscillator facing the sequencer
// Assumes: comparator answers at once to the trial code
// Notes: rc oscillator rests low while rcOn is low
`timescale 1ns/1ps
`default_nettype none
module sar_analog_model
(
  input wire logic [9:0] level,
  input wire logic [9:0] sarCode,
  input wire logic rcOn,
  output logic cmpHigh,
  output var logic rcClk
);
  // ****************************************
  // comparator and rc source
  // ****************************************
  // input at or above trial code
  assign cmpHigh = (level >= sarCode);
  // 52 ns period, free phase to clk
  initial
  begin
    rcClk = 1'b0;
    forever
    begin
      #26 rcClk = rcOn ? ~rcClk : 1'b0;
    end
  end
endmodule : sar_analog_model
`default_nettype wire

//--- verilog/adc_acq_clock_ctrl.sv
// Purpose: acquisition, conversion timing and result capture over apb
// Assumes: comparator and rc clock arrive asynchronously
// Notes: zero-wait apb answer one cycle after setup
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// [R1] three-bit acquisition select, 2 to 20 periods
// [R2] nonzero select: acquire, then convert automatically
// [R3] select zero: start converts at once
// [R4] acquisition select resets to zero
// [R5] completion clears start, sets done, resamples
// [R6] no acquisition-ended status is visible
// [R7] conversion takes 11 bit periods
// [R8] clock select maps to divisors or rc
// [R9] software picks shortest legal bit period
// [R10] rc with manual start delays one instruction
// [R11] software uses rc clock for sleep
// [R12] software clears idle-on-sleep before sleep conversion
// [R13] software keeps clock source during conversion
// [R14] software picks rc below 1 MHz
// [R15] rc above 1 MHz needs sleep
// [R16] programmed acquisition needs no software wait
// [R17] manual mode software waits acquisition time
// [R18] completion loads result high and low bytes
// [R19] clearing start aborts, result kept
// [R20] wait two bit periods before resampling
// [R21] bit-period tick from divider or rc
// [R22] sample, acquire, convert, wait state sequence
module adc_acq_clock_ctrl
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rcClk,
  input wire logic cmpHigh,
  output logic [9:0] sarCode,
  output logic sampling,
  output logic converting,
  output logic [3:0] channel,
  output logic moduleOn
);

  // ****************************************
  // declarations
  // ****************************************
  adc_seq_pkg::conv_state_e state_r, state_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  logic [2:0] dly_r, dly_nxt;
  logic [9:0] code_r, code_nxt;
  logic enable_r, enable_nxt, go_r, go_nxt, done_r, done_nxt, just_r, just_nxt;
  logic [2:0] acqSel_r, acqSel_nxt, clkSel_r, clkSel_nxt;
  logic [3:0] chan_r, chan_nxt;
  logic [7:0] resHi_r, resHi_nxt, resLo_r, resLo_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic sampling_r, sampling_nxt, converting_r, converting_nxt;
  logic cmpS1_r, cmpS2_r;
  logic tick, run, wr, doneEvt, abortEvt, abortQ_r;
  logic [3:0] bitIdx;

  // ****************************************
  // bit-period tick
  // ****************************************
  // divider restarts after an abort so the wait is two whole periods
  assign run = ((state_r == adc_seq_pkg::ST_ACQ) || (state_r == adc_seq_pkg::ST_CONV)
            || (state_r == adc_seq_pkg::ST_WAIT)) && !abortQ_r; // R20

  adc_tad_tick u_tick
  (
    .clk(clk),
    .rst_n(rst_n),
    .run(run),
    .clkSel(clkSel_r),
    .rcClk(rcClk),
    .tick(tick)
  );

  // ****************************************
  // apb slave
  // ****************************************
  assign wr = psel && penable && pready_r && pwrite;

  always_comb
  begin
    pready_nxt = psel && !penable;
    pslverr_nxt = 1'b0;
    prdata_nxt = 32'h0;
    if (psel && !penable)
    begin
      case (paddr)
        adc_seq_pkg::OFS_CONTROL_ZERO:
          prdata_nxt = {26'h0, chan_r, go_r, enable_r}; // R6
        adc_seq_pkg::OFS_CONTROL_TWO:
          prdata_nxt = {24'h0, just_r, 1'b0, acqSel_r, clkSel_r};
        adc_seq_pkg::OFS_FLAGS:
          prdata_nxt = {31'h0, done_r};
        adc_seq_pkg::OFS_RESULT_HIGH:
          prdata_nxt = {24'h0, resHi_r};
        adc_seq_pkg::OFS_RESULT_LOW:
          prdata_nxt = {24'h0, resLo_r};
        default:
          pslverr_nxt = 1'b1;
      endcase
    end
  end

  // ****************************************
  // sequencer and registers
  // ****************************************
  assign doneEvt = (state_r == adc_seq_pkg::ST_CONV) && tick
                && (cnt_r == adc_seq_pkg::CONV_TADS - 5'h01);
  assign abortEvt = ((state_r == adc_seq_pkg::ST_CONV) || (state_r == adc_seq_pkg::ST_ACQ))
                 && !go_r;
  assign bitIdx = 4'h9 - cnt_r[3:0];

  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    dly_nxt = dly_r;
    code_nxt = code_r;
    enable_nxt = enable_r;
    go_nxt = go_r;
    done_nxt = done_r;
    just_nxt = just_r;
    acqSel_nxt = acqSel_r;
    clkSel_nxt = clkSel_r;
    chan_nxt = chan_r;
    resHi_nxt = resHi_r;
    resLo_nxt = resLo_r;
    case (state_r)
      adc_seq_pkg::ST_SAMPLE:
      begin
        cnt_nxt = 5'h00;
        if (enable_r && go_r)
        begin
          code_nxt = 10'h200;
          if (acqSel_r != 3'h0)
            state_nxt = adc_seq_pkg::ST_ACQ; // R2
          else if (adc_seq_pkg::isRcSel(clkSel_r))
          begin
            state_nxt = adc_seq_pkg::ST_DELAY; // R10
            dly_nxt = 3'h0;
          end
          else
            state_nxt = adc_seq_pkg::ST_CONV; // R3
        end
      end
      adc_seq_pkg::ST_DELAY:
      begin
        dly_nxt = dly_r + 3'h1;
        if (dly_r == adc_seq_pkg::INSTR_CLKS - 3'h1)
          state_nxt = adc_seq_pkg::ST_CONV; // R10
      end
      adc_seq_pkg::ST_ACQ:
      begin
        if (tick)
        begin
          cnt_nxt = cnt_r + 5'h01; // R21
          if (cnt_r == adc_seq_pkg::acqTads(acqSel_r) - 5'h01)
          begin
            state_nxt = adc_seq_pkg::ST_CONV; // R2
            cnt_nxt = 5'h00;
          end
        end
      end
      adc_seq_pkg::ST_CONV:
      begin
        if (tick)
        begin
          cnt_nxt = cnt_r + 5'h01; // R7
          if (cnt_r < 5'h0a)
          begin
            code_nxt[bitIdx] = cmpS2_r;
            if (bitIdx != 4'h0)
              code_nxt[bitIdx - 4'h1] = 1'b1;
          end
          if (doneEvt)
          begin
            state_nxt = adc_seq_pkg::ST_WAIT;
            cnt_nxt = 5'h00;
            go_nxt = 1'b0; // R5
            done_nxt = 1'b1; // R5
            if (just_r)
            begin
              resHi_nxt = {6'h00, code_r[9:8]}; // R18
              resLo_nxt = code_r[7:0];
            end
            else
            begin
              resHi_nxt = code_r[9:2]; // R18
              resLo_nxt = {code_r[1:0], 6'h00};
            end
          end
        end
      end
      adc_seq_pkg::ST_WAIT:
      begin
        if (tick)
        begin
          cnt_nxt = cnt_r + 5'h01;
          if (cnt_r == adc_seq_pkg::WAIT_TADS - 5'h01)
            state_nxt = adc_seq_pkg::ST_SAMPLE; // R20
        end
      end
      default:
        state_nxt = adc_seq_pkg::ST_SAMPLE;
    endcase
    if (abortEvt)
    begin
      state_nxt = adc_seq_pkg::ST_WAIT; // R19
      cnt_nxt = 5'h00;
    end
    if (wr)
    begin
      case (paddr)
        adc_seq_pkg::OFS_CONTROL_ZERO:
        begin
          enable_nxt = pwdata[adc_seq_pkg::BIT_ENABLE];
          go_nxt = pwdata[adc_seq_pkg::BIT_START] && pwdata[adc_seq_pkg::BIT_ENABLE];
          chan_nxt = pwdata[adc_seq_pkg::POS_CHANNEL +: 4];
        end
        adc_seq_pkg::OFS_CONTROL_TWO:
        begin
          just_nxt = pwdata[adc_seq_pkg::BIT_JUSTIFY];
          acqSel_nxt = pwdata[adc_seq_pkg::POS_ACQ +: 3]; // R1
          clkSel_nxt = pwdata[adc_seq_pkg::POS_CLKSEL +: 3]; // R8
        end
        adc_seq_pkg::OFS_FLAGS:
          if (pwdata[adc_seq_pkg::BIT_DONE] && !doneEvt)
            done_nxt = 1'b0;
        adc_seq_pkg::OFS_RESULT_HIGH:
          resHi_nxt = pwdata[7:0];
        adc_seq_pkg::OFS_RESULT_LOW:
          resLo_nxt = pwdata[7:0];
        default:
          enable_nxt = enable_r;
      endcase
    end
    if (!enable_nxt)
      state_nxt = adc_seq_pkg::ST_SAMPLE;
    sampling_nxt = enable_nxt && ((state_nxt == adc_seq_pkg::ST_SAMPLE)
                || (state_nxt == adc_seq_pkg::ST_ACQ) || (state_nxt == adc_seq_pkg::ST_DELAY)); // R5
    converting_nxt = state_nxt == adc_seq_pkg::ST_CONV; // R22
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_r <= adc_seq_pkg::ST_SAMPLE;
      cnt_r <= 5'h00;
      dly_r <= 3'h0;
      code_r <= 10'h000;
      enable_r <= 1'b0;
      go_r <= 1'b0;
      done_r <= 1'b0;
      just_r <= 1'b0;
      acqSel_r <= adc_seq_pkg::RST_ACQ; // R4
      clkSel_r <= adc_seq_pkg::RST_CLKSEL;
      chan_r <= adc_seq_pkg::RST_CHANNEL;
      resHi_r <= 8'h00;
      resLo_r <= 8'h00;
      prdata_r <= 32'h0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      sampling_r <= 1'b0;
      converting_r <= 1'b0;
      cmpS1_r <= 1'b0;
      cmpS2_r <= 1'b0;
      abortQ_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      dly_r <= dly_nxt;
      code_r <= code_nxt;
      enable_r <= enable_nxt;
      go_r <= go_nxt;
      done_r <= done_nxt;
      just_r <= just_nxt;
      acqSel_r <= acqSel_nxt;
      clkSel_r <= clkSel_nxt;
      chan_r <= chan_nxt;
      resHi_r <= resHi_nxt;
      resLo_r <= resLo_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      sampling_r <= sampling_nxt;
      converting_r <= converting_nxt;
      cmpS1_r <= cmpHigh;
      cmpS2_r <= cmpS1_r;
      abortQ_r <= abortEvt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign sarCode = code_r;
  assign sampling = sampling_r;
  assign converting = converting_r;
  assign channel = chan_r;
  assign moduleOn = enable_r;

  // ****************************************
  // assertions
  // ****************************************
  property p_acqReset;
    @(posedge clk) disable iff (!rst_n)
    (rst_n && !$past(rst_n)) |-> (acqSel_r == 3'h0 && state_r == adc_seq_pkg::ST_SAMPLE);
  endproperty
  a_acqReset: assert property (p_acqReset) else $error("acquisition select not zero"); // R4

  property p_manualStart;
    @(posedge clk) disable iff (!rst_n)
    (state_r == adc_seq_pkg::ST_SAMPLE && go_r && enable_r && acqSel_r == 3'h0
     && !adc_seq_pkg::isRcSel(clkSel_r) && !wr) |=> converting;
  endproperty
  a_manualStart: assert property (p_manualStart) else $error("manual start not immediate"); // R3

  property p_autoStart;
    @(posedge clk) disable iff (!rst_n)
    (state_r == adc_seq_pkg::ST_SAMPLE && go_r && enable_r && acqSel_r != 3'h0 && !wr)
    |=> (state_r == adc_seq_pkg::ST_ACQ && !converting);
  endproperty
  a_autoStart: assert property (p_autoStart) else $error("acquisition phase skipped"); // R2

  property p_acqLength;
    @(posedge clk) disable iff (!rst_n)
    (state_r == adc_seq_pkg::ST_ACQ && $past(state_r) != adc_seq_pkg::ST_ACQ)
    |-> cnt_r == 5'h00;
  endproperty
  a_acqLength: assert property (p_acqLength) else $error("acquisition count not cleared"); // R1

  property p_complete;
    @(posedge clk) disable iff (!rst_n)
    (doneEvt && !wr) |=> (!go_r && done_r && state_r == adc_seq_pkg::ST_WAIT);
  endproperty
  a_complete: assert property (p_complete) else $error("completion flags wrong"); // R5

  property p_convLength;
    @(posedge clk) disable iff (!rst_n)
    doneEvt |-> (cnt_r == 5'h0a && tick && go_r);
  endproperty
  a_convLength: assert property (p_convLength) else $error("conversion length wrong"); // R7

  property p_abortKeeps;
    @(posedge clk) disable iff (!rst_n)
    (abortEvt && !wr) |=> ($stable(resHi_r) && $stable(resLo_r)
                          && state_r == adc_seq_pkg::ST_WAIT);
  endproperty
  a_abortKeeps: assert property (p_abortKeeps) else $error("abort changed result"); // R19

  property p_waitHold;
    @(posedge clk) disable iff (!rst_n)
    (state_r == adc_seq_pkg::ST_WAIT && enable_r && !wr
     && !(tick && cnt_r == adc_seq_pkg::WAIT_TADS - 5'h01))
    |=> state_r == adc_seq_pkg::ST_WAIT;
  endproperty
  a_waitHold: assert property (p_waitHold) else $error("post-conversion wait cut short"); // R20

  property p_rcDelay;
    @(posedge clk) disable iff (!rst_n)
    (state_r == adc_seq_pkg::ST_SAMPLE && go_r && enable_r && acqSel_r == 3'h0
     && adc_seq_pkg::isRcSel(clkSel_r) && !wr)
    |=> (!converting && go_r) [*4] ##1 (converting || !enable_r || !go_r);
  endproperty
  a_rcDelay: assert property (p_rcDelay) else $error("rc start delay wrong"); // R10

endmodule : adc_acq_clock_ctrl
`default_nettype wire

//--- verilog/adc_tad_tick.sv
// Purpose: bit-period tick from oscillator divider or rc source
// Assumes: rcClk is asynchronous to clk
// Notes: counter restarts whenever run is low
`timescale 1ns/1ps
`default_nettype none
module adc_tad_tick
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [2:0] clkSel,
  input wire logic rcClk,
  output logic tick
);

  // ****************************************
  // rc synchroniser and divider
  // ****************************************
  logic rcS1_r, rcS2_r, rcS3_r;
  logic [6:0] div_r, div_nxt;
  logic tick_r, tick_nxt;

  always_comb
  begin
    div_nxt = 7'h00;
    tick_nxt = 1'b0;
    if (run)
    begin
      if (adc_seq_pkg::isRcSel(clkSel))
      begin
        tick_nxt = rcS2_r & ~rcS3_r; // R21
      end
      else if (div_r == adc_seq_pkg::tadDivisor(clkSel) - 7'h01)
      begin
        tick_nxt = 1'b1; // R8
      end
      else
      begin
        div_nxt = div_r + 7'h01;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rcS1_r <= 1'b0;
      rcS2_r <= 1'b0;
      rcS3_r <= 1'b0;
      div_r <= 7'h00;
      tick_r <= 1'b0;
    end
    else
    begin
      rcS1_r <= rcClk;
      rcS2_r <= rcS1_r;
      rcS3_r <= rcS2_r;
      div_r <= div_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r;

  property p_div2;
    @(posedge clk) disable iff (!rst_n)
    (tick && run && clkSel == 3'h0) ##1 (run && clkSel == 3'h0) |-> ##1 tick;
  endproperty
  a_div2: assert property (p_div2) else $error("divide-by-2 tick missing"); // R8

endmodule : adc_tad_tick
`default_nettype wire
